/* File: liu_ja_cfg.svh */
/*
  Offsets, field positions, reset values, pattern codes and timing counts
  for the attenuator and test pattern control block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LIU_JA_CFG_SVH
`define LIU_JA_CFG_SVH

`define ADDR_W 5
`define ATTEN_CFG_OFS 5'h01
`define RX_PAT_OFS 5'h02
`define STATUS_OFS 5'h1e

`define ATTEN_CFG_RST 8'h00
`define RX_PAT_RST 8'h00

`define BIT_PATH_HI 3
`define BIT_PATH_LO 2
`define BIT_NARROW_BW 1
`define BIT_DEPTH_SEL 0
`define BIT_RX_ON 7
`define BIT_PAT_HI 6
`define BIT_PAT_LO 4

`define PAT_CODE_ONES 3'h4
`define PAT_CODE_UP 3'h5
`define PAT_CODE_DOWN 3'h6

`define DEPTH_SHALLOW 7'h20
`define DEPTH_DEEP 7'h40

`define LOOP_UP_LEN 3'h5
`define LOOP_DOWN_LEN 3'h3

`define CLK_MHZ 25
`define TX_STALL_NS 2000
`define TX_STALL_CYC ((`TX_STALL_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: liu_ja_pkg.sv */
/*
  Types and the shared pattern decode for the attenuator and test pattern
  control block. Assumes the constants header is on the include path.
*/
`include "liu_ja_cfg.svh"

package liu_ja_pkg;

  typedef enum logic [1:0] {
    PAT_NONE = 2'b00,
    PAT_ONES = 2'b01,
    PAT_UP = 2'b11,
    PAT_DOWN = 2'b10
  } pattern_t;

  typedef enum logic [1:0] {
    PATH_OFF = 2'b00,
    PATH_TX = 2'b01,
    PATH_RX = 2'b10
  } atten_path_t;

  function automatic pattern_t decode_pattern(input logic [2:0] code);
    pattern_t p;
    p = PAT_NONE;
    case (code)
      `PAT_CODE_ONES: p = PAT_ONES;
      `PAT_CODE_UP: p = PAT_UP;
      `PAT_CODE_DOWN: p = PAT_DOWN;
      default: p = PAT_NONE;
    endcase
    return p;
  endfunction

endpackage

/* File: tx_pattern_gen.sv */
/*
  Transmit line bit source: normal data or one of the repeating test
  patterns, advanced once per transmit bit.
  Assumes bit_en is a one-cycle pulse per transmit clock rising edge.
*/
`include "liu_ja_cfg.svh"

module tx_pattern_gen
  import liu_ja_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bit_en,
  input wire logic restart,
  input wire pattern_t mode,
  input wire logic data_in,
  output logic line_bit
);

  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [2:0] pat_len;
  logic line_bit_r;
  logic line_bit_nxt;
  logic last_phase;

  assign pat_len = (mode == PAT_UP) ? `LOOP_UP_LEN : `LOOP_DOWN_LEN;
  assign last_phase = (phase_r == pat_len - 3'h1);
  // A restart sends phase 0 at once, so the next bit is phase 1
  assign phase_nxt = restart ? 3'h1 : last_phase ? 3'h0 : phase_r + 3'h1;

  always_comb begin
    line_bit_nxt = data_in;
    case (mode)
      PAT_ONES: line_bit_nxt = 1'b1;
      PAT_UP: line_bit_nxt = last_phase && !restart;
      PAT_DOWN: line_bit_nxt = last_phase && !restart;
      default: line_bit_nxt = data_in;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 3'h0;
      line_bit_r <= 1'b0;
    end else if (bit_en) begin
      phase_r <= phase_nxt;
      line_bit_r <= line_bit_nxt;
    end
  end

  assign line_bit = line_bit_r;

endmodule

/* File: liu_ja_ctrl.sv */
/*
  Host-programmed control for one line interface channel: attenuator
  placement, bandwidth and depth, receiver power, and transmit test patterns.
  Assumes a plain register port on clk, all inputs synchronous to clk, and
  a transmit clock slower than clk/2 so each of its edges is seen.
*/
// Decided for this implementation: the address-and-strobe port.
// Overview of operation
// - Receiver power bit: 1 enables receiver, 0 shuts it and floats pins.
// - Three pattern select bits together choose which test pattern goes out.
// - All-ones selection sends continuous marks instead of normal data.
// - Loop-up selection repeatedly sends the bit sequence 00001.
// - While sending loop-up, ignore loop-code detection, no remote loop-back.
// - Loop-down selection repeatedly sends the bit sequence 001.
// - E1 with narrow bandwidth forces attenuator depth to 64 bits.
`include "liu_ja_cfg.svh"

module liu_ja_ctrl
  import liu_ja_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int STALL_CYCLES = `TX_STALL_CYC,
  parameter int STALL_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic e1_mode,
  input wire logic tx_clock_in,
  input wire logic tx_data_in,
  output logic tx_data_out,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  output logic rx_line_oe,
  output logic rx_pos_data,
  output logic rx_neg_data,
  output logic receiver_power_on,
  output logic atten_in_tx,
  output logic atten_in_rx,
  output logic atten_narrow_bw,
  output logic [6:0] atten_depth,
  input wire logic auto_loop_detect_cfg_hi,
  input wire logic auto_loop_detect_cfg_lo,
  input wire logic loop_code_seen,
  output logic remote_loop_activate,
  output logic [3:0] term_ctrl,
  output logic [3:0] loop_ctrl
);

  localparam logic [STALL_W-1:0] STALL_MAX = STALL_W'(STALL_CYCLES);

  logic [7:0] atten_cfg_r;
  logic [7:0] rx_pat_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status_word;

  logic sel_atten_cfg;
  logic sel_rx_pat;
  logic sel_status;
  logic wr_atten_cfg;
  logic wr_rx_pat;

  logic tx_clk_d_r;
  logic bit_en;

  pattern_t mode_r;
  pattern_t mode_nxt;
  pattern_t mode_req;
  logic mode_restart;

  logic [STALL_W-1:0] stall_cnt_r;
  logic [STALL_W-1:0] stall_cnt_nxt;
  logic tx_clock_stalled;

  atten_path_t path;
  logic depth_forced;
  logic depth_deep;

  logic rx_pos_r;
  logic rx_neg_r;
  logic loop_detect_armed;
  logic loop_detect_blocked;
  logic remote_loop_r;
  logic remote_loop_nxt;

  // Address decode
  assign sel_atten_cfg = (reg_addr == `ATTEN_CFG_OFS);
  assign sel_rx_pat = (reg_addr == `RX_PAT_OFS);
  assign sel_status = (reg_addr == `STATUS_OFS);
  assign wr_atten_cfg = reg_wr && sel_atten_cfg;
  assign wr_rx_pat = reg_wr && sel_rx_pat;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      atten_cfg_r <= `ATTEN_CFG_RST;
    end else if (wr_atten_cfg) begin
      atten_cfg_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_pat_r <= `RX_PAT_RST;
    end else if (wr_rx_pat) begin
      rx_pat_r <= reg_wdata;
    end
  end

  // Unmapped addresses read as zero
  assign rdata_nxt = !reg_rd ? 8'h00 :
                     sel_atten_cfg ? atten_cfg_r :
                     sel_rx_pat ? rx_pat_r :
                     sel_status ? status_word :
                     8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  assign status_word = {2'b00,
                        loop_detect_blocked,
                        depth_deep,
                        tx_clock_stalled,
                        mode_r == PAT_DOWN,
                        mode_r == PAT_UP,
                        mode_r == PAT_ONES};

  assign path = atten_cfg_r[`BIT_PATH_HI] ? PATH_RX :
                atten_cfg_r[`BIT_PATH_LO] ? PATH_TX :
                PATH_OFF;
  assign atten_in_tx = (path == PATH_TX);
  assign atten_in_rx = (path == PATH_RX);
  assign atten_narrow_bw = atten_cfg_r[`BIT_NARROW_BW];

  assign depth_forced = e1_mode && atten_cfg_r[`BIT_NARROW_BW];
  assign depth_deep = depth_forced || atten_cfg_r[`BIT_DEPTH_SEL];
  assign atten_depth = depth_deep ? `DEPTH_DEEP : `DEPTH_SHALLOW;

  // Bits kept for neighbouring blocks, no behaviour here
  assign term_ctrl = atten_cfg_r[7:4];
  assign loop_ctrl = rx_pat_r[3:0];

  assign receiver_power_on = rx_pat_r[`BIT_RX_ON];
  assign rx_line_oe = receiver_power_on;

  // Powered-off receiver presents quiet data, not stale line levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_pos_r <= 1'b0;
      rx_neg_r <= 1'b0;
    end else begin
      rx_pos_r <= receiver_power_on && rx_line_pos;
      rx_neg_r <= receiver_power_on && rx_line_neg;
    end
  end

  assign rx_pos_data = rx_pos_r;
  assign rx_neg_data = rx_neg_r;

  // Transmit clock is a synchronous input, so a rising edge is one delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_clk_d_r <= 1'b0;
    end else begin
      tx_clk_d_r <= tx_clock_in;
    end
  end

  assign bit_en = tx_clock_in && !tx_clk_d_r;

  assign mode_req = decode_pattern(rx_pat_r[`BIT_PAT_HI:`BIT_PAT_LO]);

  // Mode only moves on a bit boundary so no pattern is cut mid-bit
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      PAT_NONE: mode_nxt = bit_en ? mode_req : PAT_NONE;
      PAT_ONES: mode_nxt = bit_en ? mode_req : PAT_ONES;
      PAT_UP: mode_nxt = bit_en ? mode_req : PAT_UP;
      PAT_DOWN: mode_nxt = bit_en ? mode_req : PAT_DOWN;
      default: mode_nxt = PAT_NONE;
    endcase
  end

  assign mode_restart = bit_en && (mode_req != mode_r);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= PAT_NONE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  tx_pattern_gen u_gen (
    .clk(clk),
    .nrst(nrst),
    .bit_en(bit_en),
    .restart(mode_restart),
    .mode(mode_nxt),
    .data_in(tx_data_in),
    .line_bit(tx_data_out)
  );

  // flag a stopped clock while sending all-ones
  // The block cannot make marks without edges; software sees the stall bit
  assign stall_cnt_nxt = (bit_en || mode_r != PAT_ONES) ? '0 :
                         (stall_cnt_r == STALL_MAX) ? stall_cnt_r :
                         stall_cnt_r + 1'b1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_r <= '0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
    end
  end

  assign tx_clock_stalled = (stall_cnt_r == STALL_MAX);

  // block loop activation
  // Taken from the requested mode too, so a reply arriving before the
  // first loop-up bit is already ignored
  assign loop_detect_armed = auto_loop_detect_cfg_hi && auto_loop_detect_cfg_lo;
  assign loop_detect_blocked = (mode_r == PAT_UP) || (mode_req == PAT_UP);
  assign remote_loop_nxt = loop_detect_armed && loop_code_seen && !loop_detect_blocked;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remote_loop_r <= 1'b0;
    end else begin
      remote_loop_r <= remote_loop_nxt;
    end
  end

  assign remote_loop_activate = remote_loop_r;

endmodule

/* File: liu_ja_ctrl_properties.sv */
/* Port checker for liu_ja_ctrl.
   Assumes it is bound into every liu_ja_ctrl instance. */
`include "liu_ja_cfg.svh"
module liu_ja_ctrl_chk #(
  parameter int ADDR_W = `ADDR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic e1_mode,
  input wire logic rx_line_oe,
  input wire logic rx_pos_data,
  input wire logic rx_neg_data,
  input wire logic receiver_power_on,
  input wire logic atten_in_tx,
  input wire logic atten_in_rx,
  input wire logic atten_narrow_bw,
  input wire logic [6:0] atten_depth,
  input wire logic auto_loop_detect_cfg_hi,
  input wire logic auto_loop_detect_cfg_lo,
  input wire logic loop_code_seen,
  input wire logic remote_loop_activate
);
  timeunit 1ns;
  timeprecision 1ns;
  logic up_r;
  logic up_nxt;
  wire pat_wr = reg_wr && reg_addr == ADDR_W'(`RX_PAT_OFS);
  wire cfg_wr = reg_wr && reg_addr == ADDR_W'(`ATTEN_CFG_OFS);
  // Mirror of a loop-up selection, so blocking can be judged
  assign up_nxt = pat_wr ? reg_wdata[6:4] == `PAT_CODE_UP : up_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_r <= 1'b0;
    else up_r <= up_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Writes excluded: a pending loop-up request may block early
  sequence armed_s;
    auto_loop_detect_cfg_hi && auto_loop_detect_cfg_lo && loop_code_seen && !up_r && !reg_wr;
  endsequence
  chk_power_write: assert property (
    pat_wr |=> receiver_power_on == $past(reg_wdata[7])) else $error("power bit wrong");
  chk_oe_power: assert property (
    rx_line_oe == receiver_power_on) else $error("oe differs from power");
  chk_rx_quiet: assert property (
    !receiver_power_on [*2] |-> !rx_pos_data && !rx_neg_data) else $error("rx data while off");
  chk_path_write: assert property (
    cfg_wr |=> atten_in_tx == ($past(reg_wdata[3:2]) == 2'b01) &&
    atten_in_rx == $past(reg_wdata[3])) else $error("path decode wrong");
  chk_path_excl: assert property (
    !(atten_in_tx && atten_in_rx)) else $error("two paths at once");
  chk_e1_forced: assert property (
    e1_mode && atten_narrow_bw |-> atten_depth == `DEPTH_DEEP) else $error("e1 depth not 64");
  chk_depth_write: assert property (
    cfg_wr && !e1_mode ##1 !e1_mode |-> atten_depth ==
    ($past(reg_wdata[0]) ? `DEPTH_DEEP : `DEPTH_SHALLOW)) else $error("depth wrong");
  chk_loop_blocked: assert property (
    up_r && $past(up_r) |-> !remote_loop_activate) else $error("loop-back while loop-up");
  chk_loop_arms: assert property (
    armed_s ##1 armed_s |=> remote_loop_activate) else $error("loop-back not raised");
endmodule

bind liu_ja_ctrl liu_ja_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .e1_mode(e1_mode),
  .rx_line_oe(rx_line_oe), .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data),
  .receiver_power_on(receiver_power_on), .atten_in_tx(atten_in_tx),
  .atten_in_rx(atten_in_rx), .atten_narrow_bw(atten_narrow_bw), .atten_depth(atten_depth),
  .auto_loop_detect_cfg_hi(auto_loop_detect_cfg_hi),
  .auto_loop_detect_cfg_lo(auto_loop_detect_cfg_lo), .loop_code_seen(loop_code_seen),
  .remote_loop_activate(remote_loop_activate));

/* File: line_model.sv */
/* Line side partner: transmit clock and receive line levels.
   Assumes clk and nrst are those of the block. */
module line_model (
  input wire logic clk,
  input wire logic nrst,
  output logic tx_clock_in,
  output logic rx_line_pos,
  output logic rx_line_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_r;
  // clock kept running
  // Eight block cycles per bit, so every edge is seen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) div_r <= 3'h0;
    else div_r <= div_r + 3'h1;
  end
  assign tx_clock_in = div_r[2];
  assign rx_line_pos = div_r[0];
  assign rx_line_neg = ~div_r[0];
endmodule

/* File: tb_top.sv */
/* Testbench for liu_ja_ctrl.
   Assumes line_model drives the line side and the checker is bound. */
`include "liu_ja_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, reg_wr, reg_rd, e1_mode, tx_clock_in, tx_data_in, tx_data_out;
  logic rx_line_pos, rx_line_neg, rx_line_oe, rx_pos_data, rx_neg_data, receiver_power_on;
  logic atten_in_tx, atten_in_rx, atten_narrow_bw, cfg_hi, cfg_lo, seen, remote;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] atten_depth;
  int errors;
  int cmp_count;
  liu_ja_ctrl i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e1_mode(e1_mode),
    .tx_clock_in(tx_clock_in), .tx_data_in(tx_data_in), .tx_data_out(tx_data_out),
    .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .rx_line_oe(rx_line_oe),
    .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data),
    .receiver_power_on(receiver_power_on), .atten_in_tx(atten_in_tx),
    .atten_in_rx(atten_in_rx), .atten_narrow_bw(atten_narrow_bw), .atten_depth(atten_depth),
    .auto_loop_detect_cfg_hi(cfg_hi), .auto_loop_detect_cfg_lo(cfg_lo),
    .loop_code_seen(seen), .remote_loop_activate(remote), .term_ctrl(), .loop_ctrl());
  line_model i_line (.clk(clk), .nrst(nrst), .tx_clock_in(tx_clock_in),
    .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg));
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bit is settled one edge after the transmit edge; sampled four edges after it
  task automatic sync_bit();
    @(posedge tx_clock_in);
    repeat (4) @(posedge clk);
  endtask
  task automatic tx_bit(input logic exp);
    sync_bit();
    #1;
    chk(tx_data_out, exp);
  endtask
  function automatic logic exp_bit(input int c, input int k);
    if (c == `PAT_CODE_ONES || c == 7) return 1'b1;
    if (c == `PAT_CODE_UP) return k % 5 == 4;
    if (c == `PAT_CODE_DOWN) return k % 3 == 2;
    return 1'b0;
  endfunction
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    {nrst, reg_wr, reg_rd, e1_mode, tx_data_in, cfg_hi, cfg_lo, seen} = 8'h00;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`ATTEN_CFG_OFS, `ATTEN_CFG_RST);
    rd(`RX_PAT_OFS, `RX_PAT_RST);
    chk(atten_depth, `DEPTH_SHALLOW);
    wr(`RX_PAT_OFS, 8'h80);
    settle(1);
    chk(rx_line_oe, 1'b1);
    chk(rx_pos_data ^ rx_neg_data, 1'b1);
    rd(`RX_PAT_OFS, 8'h80);
    wr(`RX_PAT_OFS, 8'h00);
    settle(2);
    chk({rx_line_oe, rx_pos_data, rx_neg_data}, 8'h00);
    wr(5'h05, 8'hff);
    rd(5'h05, 8'h00);
    rd(`ATTEN_CFG_OFS, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(`ATTEN_CFG_OFS, 8'(p << 2));
      settle(1);
      chk({atten_in_tx, atten_in_rx}, {p == 1, p >= 2});
    end
    for (int i = 0; i < 8; i++) begin
      wr(`ATTEN_CFG_OFS, 8'(i[1:0]));
      e1_mode <= i[2];
      settle(1);
      chk(atten_narrow_bw, i[1]);
      chk(atten_depth, i[0] || i[2] && i[1] ? `DEPTH_DEEP : `DEPTH_SHALLOW);
    end
    e1_mode <= 1'b0;
    sync_bit();
    for (int c = 0; c < 8; c++) begin
      wr(`RX_PAT_OFS, 8'h80 | 8'(c << 4));
      tx_data_in <= c == 7;
      for (int k = 0; k < 10; k++) tx_bit(exp_bit(c, k));
    end
    wr(`RX_PAT_OFS, 8'h80);
    {cfg_hi, cfg_lo, seen} <= 3'h7;
    settle(3);
    chk(remote, 1'b1);
    wr(`RX_PAT_OFS, 8'hd0);
    settle(2);
    chk(remote, 1'b0);
    settle(8);
    rd(`STATUS_OFS, 8'h32);
    chk(remote, 1'b0);
    wr(`RX_PAT_OFS, 8'h80);
    cfg_lo <= 1'b0;
    settle(3);
    chk(remote, 1'b0);
    complete_run();
  end
endmodule
